// ===== include/cise_pkg.sv
// Purpose: Shared constants, types and decode for the instruction subset executor
// Assumes: AHB-Lite word access, single clock clk_sys
// Notes  : Four clk_sys edges form one instruction cycle (decode, read, process, write)
package cise_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_INSTR      = 8'h04;
  localparam logic [7:0] ADDR_PC         = 8'h08;
  localparam logic [7:0] ADDR_FLAGS      = 8'h0C;
  localparam logic [7:0] ADDR_WORKING    = 8'h10;
  localparam logic [7:0] ADDR_BANK_SEL   = 8'h14;
  localparam logic [7:0] ADDR_INDEX_BASE = 8'h18;
  localparam logic [7:0] ADDR_SHADOWS    = 8'h1C;
  localparam logic [7:0] ADDR_STACK_TOP  = 8'h20;
  localparam logic [7:0] ADDR_STACK_PTR  = 8'h24;
  localparam logic [7:0] ADDR_DMEM_ADDR  = 8'h28;
  localparam logic [7:0] ADDR_DMEM_DATA  = 8'h2C;
  localparam logic [7:0] ADDR_WATCHDOG   = 8'h30;
  localparam logic [7:0] ADDR_EXEC_STAT  = 8'h34;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_EXT_BIT    = 0;
  localparam int CTRL_WDT_BIT    = 1;
  localparam int FLAG_C_BIT      = 0;
  localparam int FLAG_DC_BIT     = 1;
  localparam int FLAG_Z_BIT      = 2;
  localparam int FLAG_OV_BIT     = 3;
  localparam int FLAG_N_BIT      = 4;
  localparam int WDT_TIMEOUT_BIT = 16;
  localparam int WDT_PWRDN_BIT   = 17;
  localparam logic [1:0]  CTRL_RESET  = 2'h0;
  localparam logic [20:0] PC_RESET    = 21'h000000;
  localparam logic [4:0]  FLAGS_RESET = 5'h00;
  localparam logic        WDT_FLAG_RESET = 1'b1;

  // ----------------------------------------------------------------------
  // Encodings and timing
  // ----------------------------------------------------------------------
  localparam logic [3:0]  OPC_TOGGLE   = 4'h7;
  localparam logic [6:0]  OPC_CLEAR    = 7'h35;
  localparam logic [7:0]  OPC_BR_ZERO  = 8'hE0;
  localparam logic [7:0]  OPC_BR_OVF   = 8'hE4;
  localparam logic [6:0]  OPC_CALL     = 7'h76;
  localparam logic [3:0]  OPC_CALL2    = 4'hF;
  localparam logic [15:0] OPC_WDT_CLR  = 16'h0004;
  localparam logic [7:0]  ACCESS_LIMIT = 8'h5F;
  localparam logic [3:0]  ACCESS_HIGH  = 4'hF;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  localparam logic [1:0]  PH_DECODE    = 2'h0;
  localparam logic [1:0]  PH_READ      = 2'h1;
  localparam logic [1:0]  PH_PROCESS   = 2'h2;
  localparam logic [1:0]  PH_WRITE     = 2'h3;

  typedef enum {ST_IDLE, ST_WAIT2, ST_RUN, ST_NOP} cise_state_type;
  typedef enum {OP_NONE, OP_TOGGLE, OP_BR_OVF, OP_BR_ZERO, OP_CALL, OP_CLEAR, OP_WDT_CLR} cise_op_type;

  function automatic cise_op_type ciseDecode(input logic [15:0] w);
    cise_op_type op;
    op = OP_NONE;
    if (w[15:12] == OPC_TOGGLE) op = OP_TOGGLE;
    else if (w[15:9] == OPC_CLEAR) op = OP_CLEAR;
    else if (w[15:8] == OPC_BR_OVF) op = OP_BR_OVF;
    else if (w[15:8] == OPC_BR_ZERO) op = OP_BR_ZERO;
    else if (w[15:9] == OPC_CALL) op = OP_CALL;
    else if (w == OPC_WDT_CLR) op = OP_WDT_CLR;
    return op;
  endfunction

endpackage

// ===== rtl/cise_watchdog.sv
`timescale 1ns/1ps
// Purpose: Minimal watchdog counter with postscaler and status flags
// Assumes: wdtClear is a one-cycle pulse from the executor
// Notes  : Flags are active low in meaning; one means no timeout / no power-down
module cise_watchdog
  import cise_pkg::*;
#(
  parameter int CNT_W  = 16,
  parameter int POST_W = 4
)
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Control
  input  wire logic             enable,
  input  wire logic             wdtClear,
  input  wire logic             pdClear,
  // State
  output logic [CNT_W-1:0]      count,
  output logic                  timeoutFlag,
  output logic                  powerdownFlag
);

  logic [CNT_W-1:0]  count_q;
  logic [POST_W-1:0] post_q;
  logic              timeout_q;
  logic              powerdown_q;
  logic              postWrap;

  if (CNT_W < 1 || CNT_W > 16 || POST_W < 1) begin : g_chk
    $error("watchdog widths out of range");
  end

  assign postWrap      = &post_q;
  assign count         = count_q;
  assign timeoutFlag   = timeout_q;
  assign powerdownFlag = powerdown_q;

  // ----------------------------------------------------------------------
  // Counter and postscaler
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
      post_q  <= '0;
    end else if (wdtClear) begin
      count_q <= '0;
      post_q  <= '0;
    end else if (enable) begin
      post_q <= post_q + 1'b1;
      if (postWrap) count_q <= count_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags; the clear instruction wins over any competing event
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timeout_q   <= WDT_FLAG_RESET;
      powerdown_q <= WDT_FLAG_RESET;
    end else if (wdtClear) begin
      timeout_q   <= 1'b1;
      powerdown_q <= 1'b1;
    end else begin
      if (enable && postWrap && (&count_q)) timeout_q <= 1'b0;
      if (pdClear) powerdown_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_wdt_count_zero: assert property (wdtClear |=> count_q == '0)
    else $error("watchdog count not zero after clear");
  a_wdt_flags_set: assert property (wdtClear |=> post_q == '0 && timeout_q && powerdown_q)
    else $error("postscaler or status flags wrong after clear");

endmodule

// ===== rtl/cise_exec.sv
`timescale 1ns/1ps
// Purpose: Executes a subset of an 8-bit core's instructions written over AHB-Lite
// Assumes: One word-sized transfer at a time; instructions enter via the instruction register
// Notes  : Bus transfers stall while an instruction is executing
module cise_exec
  import cise_pkg::*;
#(
  parameter int STACK_DEPTH = 31,
  parameter int WDT_CNT_W   = 16
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);

  cise_state_type    state_q;
  cise_op_type       op_q;
  logic [1:0]        phase_q;
  logic [15:0]       instr_q;
  logic [15:0]       word2_q;
  logic [20:0]       pc_q;
  logic [4:0]        flags_q;
  logic [7:0]        working_q;
  logic [3:0]        bankSelectReg_q;
  logic [11:0]       indexBase_q;
  logic [7:0]        workingShadow_q;
  logic [4:0]        flagsShadow_q;
  logic [3:0]        bankSelectShadow_q;
  logic [1:0]        ctrl_q;
  logic [11:0]       dmemAddr_q;
  logic [11:0]       execAddr_q;
  logic [7:0]        rdByte_q;
  logic [7:0]        procByte_q;
  logic              taken_q;
  logic [20:0]       stack_q [STACK_DEPTH];
  logic [4:0]        sp_q;
  logic              stackOvf_q;
  logic [7:0]        dmem [4096];
  logic              dphase_q;
  logic              dWrite_q;
  logic [7:0]        dAddr_q;
  logic              rdReady_q;
  logic [31:0]       hrdata_q;
  logic [31:0]       readMux;
  logic              busy;
  logic              wrEn;
  logic              instrWr;
  logic              rdLoad;
  logic              q1Run;
  logic              q2Run;
  logic              q3Run;
  logic              q4Run;
  logic              regOp;
  logic [20:0]       branchOff;
  logic [20:0]       stackTop;
  logic [WDT_CNT_W-1:0] wdtCount;
  logic              timeoutFlag;
  logic              powerdownFlag;

  if (STACK_DEPTH < 2 || STACK_DEPTH > 31) begin : g_chk
    $error("STACK_DEPTH must lie between 2 and 31");
  end

  // Effective data address for byte and bit register operations
  function automatic logic [11:0] ciseAddr(input logic [15:0] w, input logic [3:0] bank,
                                           input logic ext, input logic [11:0] base);
    logic [11:0] a;
    a = {bank, w[7:0]};
    if (!w[8]) begin
      if (ext && w[7:0] <= ACCESS_LIMIT) a = 12'(base + {4'h0, w[7:0]});
      else if (w[7:0] <= ACCESS_LIMIT) a = {4'h0, w[7:0]};
      else a = {ACCESS_HIGH, w[7:0]};
    end
    return a;
  endfunction

  assign busy      = (state_q == ST_RUN) || (state_q == ST_NOP);
  assign wrEn      = dphase_q && dWrite_q && !busy;
  assign instrWr   = wrEn && (dAddr_q == ADDR_INSTR);
  assign rdLoad    = dphase_q && !dWrite_q && !busy && !rdReady_q;
  assign q1Run     = (state_q == ST_RUN) && (phase_q == PH_DECODE);
  assign q2Run     = (state_q == ST_RUN) && (phase_q == PH_READ);
  assign q3Run     = (state_q == ST_RUN) && (phase_q == PH_PROCESS);
  assign q4Run     = (state_q == ST_RUN) && (phase_q == PH_WRITE);
  assign regOp     = (op_q == OP_TOGGLE) || (op_q == OP_CLEAR);
  assign branchOff = {{12{instr_q[7]}}, instr_q[7:0], 1'b0};
  assign stackTop  = (sp_q == 5'h00) ? 21'h000000 : stack_q[sp_q - 5'h01];

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  // Reads take one wait state so read data leave a flip-flop
  assign hreadyout = !dphase_q || (dWrite_q ? !busy : rdReady_q);
  assign hrdata    = hrdata_q;
  assign hresp     = 1'b0;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dphase_q <= 1'b0;
      dWrite_q <= 1'b0;
      dAddr_q  <= 8'h00;
    end else if (hready) begin
      dphase_q <= hsel && htrans[1] && (hsize == 3'h2);
      dWrite_q <= hwrite;
      dAddr_q  <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdReady_q <= 1'b0;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      rdReady_q <= rdLoad;
      if (rdLoad) hrdata_q <= readMux;
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    case (dAddr_q)
      ADDR_CTRL:       readMux = {30'h0, ctrl_q};
      ADDR_INSTR:      readMux = {word2_q, instr_q};
      ADDR_PC:         readMux = {11'h000, pc_q};
      ADDR_FLAGS:      readMux = {27'h0, flags_q};
      ADDR_WORKING:    readMux = {24'h0, working_q};
      ADDR_BANK_SEL:   readMux = {28'h0, bankSelectReg_q};
      ADDR_INDEX_BASE: readMux = {20'h0, indexBase_q};
      ADDR_SHADOWS:    readMux = {12'h0, bankSelectShadow_q, 3'h0, flagsShadow_q, workingShadow_q};
      ADDR_STACK_TOP:  readMux = {11'h000, stackTop};
      ADDR_STACK_PTR:  readMux = {24'h0, stackOvf_q, 2'h0, sp_q};
      ADDR_DMEM_ADDR:  readMux = {20'h0, dmemAddr_q};
      ADDR_DMEM_DATA:  readMux = {24'h0, dmem[dmemAddr_q]};
      ADDR_WATCHDOG:   readMux = {14'h0, powerdownFlag, timeoutFlag, 16'(wdtCount)};
      ADDR_EXEC_STAT:  readMux = {28'h0, phase_q, state_q == ST_WAIT2, busy};
      default:         readMux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer: four phases per instruction cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      op_q    <= OP_NONE;
      phase_q <= PH_DECODE;
      instr_q <= 16'h0000;
      word2_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: if (instrWr) begin
          instr_q <= hwdata[15:0];
          op_q    <= ciseDecode(hwdata[15:0]);
          phase_q <= PH_DECODE;
          // A call waits for its second word before it starts
          state_q <= (ciseDecode(hwdata[15:0]) == OP_CALL) ? ST_WAIT2 : ST_RUN;
        end
        ST_WAIT2: if (instrWr) begin
          word2_q <= hwdata[15:0];
          state_q <= (hwdata[15:12] == OPC_CALL2) ? ST_RUN : ST_IDLE;
        end
        ST_RUN: begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == PH_WRITE) begin
            state_q <= (op_q == OP_CALL || taken_q) ? ST_NOP : ST_IDLE;
          end
        end
        ST_NOP: begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == PH_WRITE) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Datapath: address, read, process
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      execAddr_q <= 12'h000;
      rdByte_q   <= 8'h00;
      procByte_q <= 8'h00;
      taken_q    <= 1'b0;
    end else begin
      if (q1Run) begin
        execAddr_q <= ciseAddr(instr_q, bankSelectReg_q, ctrl_q[CTRL_EXT_BIT], indexBase_q);
        taken_q    <= 1'b0;
      end
      if (q2Run) rdByte_q <= dmem[execAddr_q];
      if (q3Run) begin
        procByte_q <= (op_q == OP_TOGGLE) ? (rdByte_q ^ (8'h01 << instr_q[11:9])) : 8'h00;
        taken_q    <= ((op_q == OP_BR_OVF) && flags_q[FLAG_OV_BIT])
                   || ((op_q == OP_BR_ZERO) && flags_q[FLAG_Z_BIT]);
      end
    end
  end

  // Bus writes to data memory never meet an executor write: they stall while busy
  always_ff @(posedge clk_sys) begin
    if (q4Run && regOp) dmem[execAddr_q] <= procByte_q;
    else if (wrEn && dAddr_q == ADDR_DMEM_DATA) dmem[dmemAddr_q] <= hwdata[7:0];
  end

  // ----------------------------------------------------------------------
  // Program counter and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= PC_RESET;
    end else if (wrEn && dAddr_q == ADDR_PC) begin
      pc_q <= {hwdata[20:1], 1'b0};
    end else if (q1Run) begin
      pc_q <= 21'(pc_q + PC_STEP);
    end else if (q4Run && taken_q) begin
      pc_q <= 21'(pc_q + branchOff);
    end else if (q4Run && op_q == OP_CALL) begin
      pc_q <= {word2_q[11:0], instr_q[7:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= FLAGS_RESET;
    end else if (wrEn && dAddr_q == ADDR_FLAGS) begin
      flags_q <= hwdata[4:0];
    end else if (q4Run && op_q == OP_CLEAR) begin
      flags_q[FLAG_Z_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Software-visible core registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q          <= CTRL_RESET;
      working_q       <= 8'h00;
      bankSelectReg_q <= 4'h0;
      indexBase_q     <= 12'h000;
      dmemAddr_q      <= 12'h000;
    end else if (wrEn) begin
      if (dAddr_q == ADDR_CTRL) ctrl_q <= hwdata[1:0];
      if (dAddr_q == ADDR_WORKING) working_q <= hwdata[7:0];
      if (dAddr_q == ADDR_BANK_SEL) bankSelectReg_q <= hwdata[3:0];
      if (dAddr_q == ADDR_INDEX_BASE) indexBase_q <= hwdata[11:0];
      if (dAddr_q == ADDR_DMEM_ADDR) dmemAddr_q <= hwdata[11:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      workingShadow_q    <= 8'h00;
      flagsShadow_q      <= FLAGS_RESET;
      bankSelectShadow_q <= 4'h0;
    end else if (q3Run && op_q == OP_CALL && instr_q[8]) begin
      workingShadow_q    <= working_q;
      flagsShadow_q      <= flags_q;
      bankSelectShadow_q <= bankSelectReg_q;
    end
  end

  // ----------------------------------------------------------------------
  // Return stack; a push onto a full stack is dropped and flagged
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sp_q       <= 5'h00;
      stackOvf_q <= 1'b0;
    end else if (q3Run && op_q == OP_CALL) begin
      if (sp_q < STACK_DEPTH) sp_q <= sp_q + 5'h01;
      else stackOvf_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (q3Run && op_q == OP_CALL && sp_q < STACK_DEPTH) begin
      stack_q[sp_q] <= 21'(pc_q + PC_STEP);
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  cise_watchdog #(
    .CNT_W  (WDT_CNT_W)
  ) u_watchdog (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .enable        (ctrl_q[CTRL_WDT_BIT]),
    .wdtClear      (q3Run && op_q == OP_WDT_CLR),
    .pdClear       (wrEn && dAddr_q == ADDR_WATCHDOG && !hwdata[WDT_PWRDN_BIT]),
    .count         (wdtCount),
    .timeoutFlag   (timeoutFlag),
    .powerdownFlag (powerdownFlag)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_toggle_bit_inv: assert property (q4Run && op_q == OP_TOGGLE |=>
    dmem[$past(execAddr_q)] == ($past(rdByte_q) ^ (8'h01 << $past(instr_q[11:9]))))
    else $error("toggle did not invert the chosen bit");
  a_bank_sel_addr: assert property (q2Run && regOp && instr_q[8] |->
    execAddr_q == {bankSelectReg_q, instr_q[7:0]})
    else $error("banked address not formed from bank select");
  a_indexed_addr: assert property (q2Run && regOp && !instr_q[8] && ctrl_q[CTRL_EXT_BIT] &&
    instr_q[7:0] <= ACCESS_LIMIT |-> execAddr_q == 12'(indexBase_q + {4'h0, instr_q[7:0]}))
    else $error("indexed literal offset address wrong");
  a_ovf_branch_pc: assert property (q4Run && op_q == OP_BR_OVF |=> pc_q ==
    ($past(flags_q[FLAG_OV_BIT]) ? 21'($past(pc_q) + $past(branchOff)) : $past(pc_q)))
    else $error("overflow branch target wrong");
  a_zero_branch_pc: assert property (q4Run && op_q == OP_BR_ZERO |=> pc_q ==
    ($past(flags_q[FLAG_Z_BIT]) ? 21'($past(pc_q) + $past(branchOff)) : $past(pc_q)))
    else $error("zero branch target wrong");
  a_branch_span: assert property (q4Run && taken_q |=> !pc_q[0] &&
    $signed(21'(pc_q - $past(pc_q))) >= -256 && $signed(21'(pc_q - $past(pc_q))) <= 254)
    else $error("branch step outside signed offset range");
  a_taken_nop_cycle: assert property (q4Run && taken_q |=>
    (state_q == ST_NOP)[*4] ##1 (state_q == ST_IDLE))
    else $error("taken branch second cycle wrong");
  a_call_wait_word: assert property (state_q == ST_IDLE && instrWr && hwdata[15:9] == OPC_CALL |=>
    state_q == ST_WAIT2)
    else $error("call first word did not wait for second");
  a_call_push_ret: assert property (q3Run && op_q == OP_CALL && sp_q < STACK_DEPTH |=>
    stackTop == 21'($past(pc_q) + PC_STEP) && sp_q == $past(sp_q) + 5'h01)
    else $error("return address push wrong");
  a_shadow_save: assert property (q3Run && op_q == OP_CALL |=>
    ($past(instr_q[8]) ? (workingShadow_q == $past(working_q) && flagsShadow_q == $past(flags_q)
      && bankSelectShadow_q == $past(bankSelectReg_q))
     : ($stable(workingShadow_q) && $stable(flagsShadow_q) && $stable(bankSelectShadow_q))))
    else $error("shadow registers handled wrongly");
  a_call_target_pc: assert property (q4Run && op_q == OP_CALL |=>
    (pc_q == {$past(word2_q[11:0]), $past(instr_q[7:0]), 1'b0}) ##0 (state_q == ST_NOP)[*4])
    else $error("call target or no-operation cycle wrong");
  a_clear_zero_flag: assert property (q4Run && op_q == OP_CLEAR |=>
    dmem[$past(execAddr_q)] == 8'h00 && flags_q[FLAG_Z_BIT])
    else $error("register clear result or zero flag wrong");
  a_flags_untouched: assert property (busy && op_q inside {OP_TOGGLE, OP_BR_OVF, OP_BR_ZERO, OP_CALL} |=>
    $stable(flags_q))
    else $error("flags changed by a flag-neutral instruction");

endmodule

// ===== dv/cise_exec_tb.sv
// Purpose: Self-checking bench for the instruction subset executor
// Assumes: One AHB-Lite slave, hready tied to hreadyout
// Notes  : Bus waits are bounded so a stalled executor cannot hang a test
`timescale 1ns/1ps
module cise_exec_tb
  import cise_pkg::*;
;
  logic        clk_sys;
  logic        reset_n;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] r;
  int          fails;
  int          tests_run;

  cise_exec DUT (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask

  // Executor busy stretches the data phase, so both waits are bounded
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 40);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 80);
    r = hrdata;
    chk("bus wait", 32'h0, {31'h0, n >= 80});
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, r);
  endtask

  task automatic t_toggle;
    wr(ADDR_BANK_SEL, 32'h2); wr(ADDR_DMEM_ADDR, 32'h234); wr(ADDR_DMEM_DATA, 32'h75);
    wr(ADDR_FLAGS, 32'h1F); wr(ADDR_PC, 32'h10); wr(ADDR_INSTR, 32'h7934);
    rd("toggled byte", ADDR_DMEM_DATA, 32'h65);
    rd("toggle pc", ADDR_PC, 32'h12);
    rd("toggle flags", ADDR_FLAGS, 32'h1F);
    wr(ADDR_CTRL, 32'h1); wr(ADDR_INDEX_BASE, 32'h300); wr(ADDR_DMEM_ADDR, 32'h310);
    wr(ADDR_DMEM_DATA, 32'h0); wr(ADDR_INSTR, 32'h7010);
    rd("indexed byte", ADDR_DMEM_DATA, 32'h1);
    $display("test toggle done");
  endtask

  task automatic t_branch;
    wr(ADDR_FLAGS, 32'h8); wr(ADDR_PC, 32'h100); wr(ADDR_INSTR, 32'hE4FE);
    rd("overflow taken pc", ADDR_PC, 32'hFE);
    rd("branch flags", ADDR_FLAGS, 32'h8);
    wr(ADDR_FLAGS, 32'h0); wr(ADDR_PC, 32'h100); wr(ADDR_INSTR, 32'hE47F);
    rd("overflow skip pc", ADDR_PC, 32'h102);
    wr(ADDR_FLAGS, 32'h4); wr(ADDR_PC, 32'h200); wr(ADDR_INSTR, 32'hE07F);
    rd("zero taken pc", ADDR_PC, 32'h300);
    wr(ADDR_FLAGS, 32'h1B); wr(ADDR_PC, 32'h200); wr(ADDR_INSTR, 32'hE080);
    rd("zero skip pc", ADDR_PC, 32'h202);
    $display("test branch done");
  endtask

  task automatic t_call;
    wr(ADDR_PC, 32'h400); wr(ADDR_WORKING, 32'h5A); wr(ADDR_FLAGS, 32'h4); wr(ADDR_BANK_SEL, 32'h3);
    wr(ADDR_INSTR, 32'hED12); wr(ADDR_INSTR, 32'hF345);
    rd("call pc", ADDR_PC, 32'h68A24);
    rd("return addr", ADDR_STACK_TOP, 32'h404);
    rd("shadows", ADDR_SHADOWS, 32'h3045A);
    wr(ADDR_WORKING, 32'h11); wr(ADDR_INSTR, 32'hEC00); wr(ADDR_INSTR, 32'hF000);
    rd("second return", ADDR_STACK_TOP, 32'h68A28);
    rd("shadows kept", ADDR_SHADOWS, 32'h3045A);
    rd("call flags", ADDR_FLAGS, 32'h4);
    // A call whose second word lacks the 1111 prefix is dropped, leaving PC, stack and shadows unchanged
    wr(ADDR_INSTR, 32'hED00); wr(ADDR_INSTR, 32'h1234);
    rd("abandoned call pc", ADDR_PC, 32'h0);
    rd("abandoned call depth", ADDR_STACK_PTR, 32'h2);
    $display("test call done");
  endtask

  task automatic t_clear;
    wr(ADDR_CTRL, 32'h0); wr(ADDR_DMEM_ADDR, 32'hF60); wr(ADDR_DMEM_DATA, 32'hAB);
    wr(ADDR_FLAGS, 32'h0); wr(ADDR_INSTR, 32'h6A60);
    rd("cleared byte", ADDR_DMEM_DATA, 32'h0);
    rd("clear flags", ADDR_FLAGS, 32'h4);
    $display("test clear done");
  endtask

  task automatic t_wdt;
    wr(ADDR_CTRL, 32'h2);
    repeat (30) @(posedge clk_sys);
    wr(ADDR_CTRL, 32'h0); wr(ADDR_WATCHDOG, 32'h0); wr(ADDR_INSTR, 32'h4);
    rd("watchdog state", ADDR_WATCHDOG, 32'h30000);
    $display("test watchdog done");
  endtask

  initial begin
    #400000;
    fails++;
    summarize();
  end

  initial begin
    fails = 0;
    tests_run = 0;
    reset_n = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_toggle(); t_branch(); t_call(); t_clear(); t_wdt();
    summarize();
  end
endmodule
